// *** i2c_ack_irq_pkg.sv ***
/*
  Shared constants and carrier types for the two-wire serial unit with
  acknowledge handling and interrupt-enable control.
  Assumes a 32-bit AHB-Lite register bus, word registers at index*4.
*/
package i2c_ack_irq_pkg;

  // ==========================================================
  // Register indices; the byte address is four times the index.
  // ==========================================================
  localparam logic [7:0] IDX_MODE = 8'hBA; // Frame and wait control.
  localparam logic [7:0] IDX_IER = 8'hBB; // Enables and acknowledge.
  localparam logic [7:0] IDX_STATUS = 8'hBC; // Sticky event flags.
  localparam logic [7:0] IDX_CTRL = 8'hBD; // Role and format select.
  localparam logic [7:0] IDX_DATA = 8'hBE; // Transmit and receive data.

  // ==========================================================
  // Reset values.
  // ==========================================================
  localparam logic [7:0] RST_MODE = 8'h18; // Guard and b4 read as one.
  localparam logic [7:0] RST_IER = 8'h00; // All requests disabled.
  localparam logic [7:0] RST_STATUS = 8'h00; // No events pending.
  localparam logic [2:0] RST_CTRL = 3'h0; // Slave, receive, two-wire.

  // ==========================================================
  // Field positions of the mode register.
  // ==========================================================
  localparam int MODE_GUARD_BIT = 3; // Counter write guard.
  localparam int MODE_FILL_BIT = 4; // Unassigned, reads as one.
  localparam int MODE_WAIT_BIT = 6; // Wait insertion before ack.
  localparam int MODE_LSB_BIT = 7; // LSB-first data order.

  // ==========================================================
  // Frame lengths in bits for code 000 of each format, wait length, general call.
  // ==========================================================
  localparam logic [3:0] FULL_TWO_WIRE = 4'h9; // Eight data plus ack.
  localparam logic [3:0] FULL_SYNC = 4'h8; // Eight data, no ack.
  localparam logic [3:0] WAIT_TICKS = 4'h2; // Extra low transfer clocks.
  localparam logic [7:0] GENERAL_CALL = 8'h00; // General call address.

  // Interrupt enable and acknowledge control, bit 7 down to bit 0.
  typedef struct packed {
    logic txEmptyIrqEnable;
    logic txEndIrqEnable;
    logic rxIrqEnable;
    logic noackIrqEnable;
    logic stopIrqEnable;
    logic ackJudgeEnable;
    logic ackReceived;
    logic ackToSend;
  } ier_type;

  // Sticky status flags, bit 7 down to bit 0.
  typedef struct packed {
    logic txEmpty;
    logic txEnd;
    logic rxFull;
    logic noack;
    logic stopSeen;
    logic arbLost;
    logic addrSeen;
    logic generalCallSeen;
  } status_type;

  // Gated request lines, one per interrupt source.
  typedef struct packed {
    logic txEmpty;
    logic txEnd;
    logic rxFull;
    logic noackErr;
    logic stopSeen;
  } irq_type;

endpackage : i2c_ack_irq_pkg

// *** i2c_ack_and_interrupt_control.sv ***
/*
  Two-wire serial unit: bit counter, acknowledge send and judgment,
  wait insertion, event flags and interrupt gating, AHB-Lite slave.
  Assumes SCL and SDA pins are asynchronous to mclk and are resolved
  by the surroundings from the output and output-enable signals.
*/
`timescale 1ns/100ps

module i2c_ack_and_interrupt_control #(
  parameter int XFER_DIV = 20, // mclk cycles per transfer clock.
  parameter int HALF_TICKS = 2 // Transfer clocks per SCL phase.
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output i2c_ack_irq_pkg::irq_type irqLines,
  output logic irq
);

  // ==========================================================
  // Register state.
  // ==========================================================
  i2c_ack_irq_pkg::ier_type ier_r; // Enables, ack select, ack seen.
  i2c_ack_irq_pkg::status_type stat_r; // Sticky event flags.
  logic [2:0] code_r; // Counter code as last set.
  logic [3:0] remain_r; // Bits still to move in this frame.
  logic waitEn_r; // Wait insertion selected.
  logic lsbFirst_r; // Data order select.
  logic [2:0] ctrl_r; // {sync format, transmit, master}.
  logic [7:0] txData_r; // Byte waiting to be sent.
  logic txFull_r; // Transmit byte present.
  logic [7:0] rxData_r; // Last byte received.
  logic [7:0] shift_r; // Bit shifter.
  logic active_r; // Frame in progress.
  logic firstFrame_r; // First frame after a start.
  logic bitVal_r; // Value placed on the data line.
  logic drvLow_r; // Two-wire: pull the data line low.

  // Bus pipeline state.
  logic wrPend_r; // Write data phase pending.
  logic [7:0] wrIdx_r; // Index captured in address phase.

  // Pin synchronisers and edge history.
  logic sclS1_r, sclS2_r, sdaS1_r, sdaS2_r, sdaPrev_r, levelPrev_r;

  // Master SCL generator.
  typedef enum {GEN_IDLE, GEN_LOW, GEN_WAIT, GEN_HIGH} gen_type;
  gen_type gen_r;
  logic sclGen_r; // Generated SCL level, one is released.
  logic [15:0] tickCnt_r; // Divider toward one transfer clock.
  logic [3:0] phaseCnt_r; // Transfer clocks spent in a phase.

  // Role decode.
  wire master = ctrl_r[0];
  wire transmit = ctrl_r[1];
  wire syncFmt = ctrl_r[2];

  // ==========================================================
  // Frame length helpers.
  // ==========================================================
  // Total bits of a frame for a code in the current format.
  function automatic logic [3:0] frameLen(input logic [2:0] c,
                                          input logic s);
    logic [3:0] full;
    full = s ? i2c_ack_irq_pkg::FULL_SYNC : i2c_ack_irq_pkg::FULL_TWO_WIRE;
    if (c == 3'h0)
      return full;
    return s ? {1'b0, c} : {1'b0, c} + 4'h1;
  endfunction : frameLen

  // Code read back for a remaining count; truncation wraps full to 000.
  function automatic logic [2:0] remainCode(input logic [3:0] r,
                                            input logic s);
    logic [3:0] v;
    v = s ? r : r - 4'h1;
    return v[2:0];
  endfunction : remainCode

  // ==========================================================
  // Bus decode.
  // ==========================================================
  wire addrPhase = hsel & htrans[1] & hready;
  wire [7:0] aIdx = haddr[9:2];
  wire rdTake = addrPhase & ~hwrite;
  wire wrMode = wrPend_r & (wrIdx_r == i2c_ack_irq_pkg::IDX_MODE);
  wire wrIer = wrPend_r & (wrIdx_r == i2c_ack_irq_pkg::IDX_IER);
  wire wrStat = wrPend_r & (wrIdx_r == i2c_ack_irq_pkg::IDX_STATUS);
  wire wrCtrl = wrPend_r & (wrIdx_r == i2c_ack_irq_pkg::IDX_CTRL);
  wire wrData = wrPend_r & (wrIdx_r == i2c_ack_irq_pkg::IDX_DATA);
  wire rdData = rdTake & (aIdx == i2c_ack_irq_pkg::IDX_DATA);
  // Counter is only rewritten when the guard bit is written as zero.
  wire wrCount = wrMode & ~hwdata[i2c_ack_irq_pkg::MODE_GUARD_BIT];

  // Mode register as read: guard and the unassigned bit read as one.
  wire [7:0] modeRd = {lsbFirst_r, waitEn_r, 1'b0, 1'b1, 1'b1,
                       active_r ? remainCode(remain_r, syncFmt) : code_r};
  wire [7:0] rdMux =
    (aIdx == i2c_ack_irq_pkg::IDX_MODE) ? modeRd :
    (aIdx == i2c_ack_irq_pkg::IDX_IER) ? ier_r :
    (aIdx == i2c_ack_irq_pkg::IDX_STATUS) ? stat_r :
    (aIdx == i2c_ack_irq_pkg::IDX_CTRL) ? {5'h00, ctrl_r} :
    (aIdx == i2c_ack_irq_pkg::IDX_DATA) ? rxData_r : 8'h00;

  // ==========================================================
  // Line events.
  // ==========================================================
  wire sclLevel = master ? sclGen_r : sclS2_r;
  wire sclRise = sclLevel & ~levelPrev_r;
  wire sclFall = ~sclLevel & levelPrev_r;
  wire sdaBus = sdaS2_r;
  wire startSeen = ~syncFmt & sclS2_r & sdaPrev_r & ~sdaBus;
  wire stopSeen = ~syncFmt & sclS2_r & ~sdaPrev_r & sdaBus;
  wire fullLen = remain_r == frameLen(code_r, syncFmt);
  wire ackBit = ~syncFmt & (remain_r == 4'h1);
  wire lastBit = remain_r == 4'h1;
  wire launch = master & ~active_r & txFull_r;
  // The data bit leaving the shifter, in the selected order.
  wire outBit = lsbFirst_r ? shift_r[0] : shift_r[7];
  wire [7:0] shiftMove = lsbFirst_r ? {1'b0, shift_r[7:1]}
                                    : {shift_r[6:0], 1'b0};
  wire [7:0] shiftIn = lsbFirst_r ? {sdaBus, shift_r[7:1]}
                                  : {shift_r[6:0], sdaBus};
  // Two-wire: the ack rise is not shifted, so the byte is already whole.
  wire [7:0] rxByte = syncFmt ? shiftIn : shift_r;
  // Wait insertion counts only for a two-wire master.
  wire waitUse = waitEn_r & master & ~syncFmt;
  // Data bits presented at a fall or at a master launch.
  wire present = active_r & sclFall;
  wire sample = active_r & sclRise;
  wire judgeHalt = sample & ackBit & transmit & ier_r.ackJudgeEnable &
                   sdaBus;
  wire arbHit = sample & ~ackBit & transmit & master & ~syncFmt &
                bitVal_r & ~sdaBus;
  wire frameEnd = sample & lastBit;
  wire overrun = frameEnd & ~transmit & syncFmt & stat_r.rxFull;
  wire txTake = (present | launch) & fullLen & transmit & txFull_r;
  wire tick = tickCnt_r == 16'(XFER_DIV - 1);

  // Sticky event sets; each wins over a clear in the same cycle.
  wire [7:0] setVec = {txTake,
                       frameEnd & transmit & stat_r.txEmpty,
                       frameEnd & ~transmit,
                       judgeHalt,
                       stopSeen,
                       arbHit | overrun,
                       1'b0,
                       frameEnd & firstFrame_r & ~transmit &
                       (rxByte == i2c_ack_irq_pkg::GENERAL_CALL)};
  wire [7:0] clrVec = (wrStat ? hwdata[7:0] : 8'h00) |
                      (wrData ? 8'hC0 : 8'h00) |
                      (rdData ? 8'h20 : 8'h00);

  // Each request is its flag AND its enable; arbLost also feeds the noack line, and the receive line when synchronous.
  wire [4:0] reqVec = {
    stat_r.txEmpty & ier_r.txEmptyIrqEnable,
    stat_r.txEnd & ier_r.txEndIrqEnable,
    (stat_r.rxFull | (stat_r.arbLost & syncFmt)) &
      ier_r.rxIrqEnable,
    (stat_r.noack | stat_r.arbLost) & ier_r.noackIrqEnable,
    stat_r.stopSeen & ier_r.stopIrqEnable};

  // ==========================================================
  // Synchronisers: the first stage feeds only the second.
  // ==========================================================
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      {sclS1_r, sclS2_r, sdaS1_r, sdaS2_r} <= 4'hF;
      sdaPrev_r <= 1'b1;
      levelPrev_r <= 1'b1;
    end
    else
    begin
      sclS1_r <= sclIn;
      sclS2_r <= sclS1_r;
      sdaS1_r <= sdaIn;
      sdaS2_r <= sdaS1_r;
      sdaPrev_r <= sdaS2_r;
      levelPrev_r <= sclLevel;
    end
  end

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY.
  // ==========================================================
  // Read data is fetched in the address phase so it comes from a flop.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPend_r <= 1'b0;
      wrIdx_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wrPend_r <= addrPhase & hwrite;
      wrIdx_r <= aIdx;
      if (rdTake)
        hrdata <= {24'h00_0000, rdMux};
    end
  end

  // ==========================================================
  // Software-owned registers.
  // ==========================================================
  // The enable register starts cleared, so all requests are off.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ier_r <= i2c_ack_irq_pkg::RST_IER;
      waitEn_r <= i2c_ack_irq_pkg::RST_MODE[i2c_ack_irq_pkg::MODE_WAIT_BIT];
      lsbFirst_r <= i2c_ack_irq_pkg::RST_MODE[i2c_ack_irq_pkg::MODE_LSB_BIT];
      ctrl_r <= i2c_ack_irq_pkg::RST_CTRL;
      txData_r <= 8'h00;
      txFull_r <= 1'b0;
    end
    else
    begin
      // Software sets enables; the received acknowledge is hardware's.
      if (wrIer)
        ier_r <= {hwdata[7:2], ier_r.ackReceived, hwdata[0]};
      // Returned acknowledge captured at the ack clock rise.
      if (sample & ackBit & transmit)
        ier_r.ackReceived <= sdaBus;
      if (wrMode)
      begin
        waitEn_r <= hwdata[i2c_ack_irq_pkg::MODE_WAIT_BIT];
        lsbFirst_r <= hwdata[i2c_ack_irq_pkg::MODE_LSB_BIT];
      end
      if (wrCtrl)
        ctrl_r <= hwdata[2:0];
      // A fresh byte replaces the waiting one; the take empties it.
      if (wrData)
        txData_r <= hwdata[7:0];
      if (wrData)
        txFull_r <= 1'b1;
      else if (txTake | (launch & ~transmit))
        txFull_r <= 1'b0;
    end
  end

  // ==========================================================
  // Status flags and interrupt outputs.
  // ==========================================================
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      stat_r <= i2c_ack_irq_pkg::RST_STATUS;
      irqLines <= '0;
      irq <= 1'b0;
    end
    else
    begin
      stat_r <= (stat_r & ~clrVec) | setVec;
      irqLines <= reqVec;
      irq <= |reqVec;
    end
  end

  // ==========================================================
  // Bit counter and shifter.
  // ==========================================================
  // A frame ends after the last bit (with ack in two-wire format).
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      code_r <= i2c_ack_irq_pkg::RST_MODE[2:0];
      remain_r <= i2c_ack_irq_pkg::FULL_TWO_WIRE;
      active_r <= 1'b0;
      firstFrame_r <= 1'b0;
      shift_r <= 8'h00;
      rxData_r <= 8'h00;
      bitVal_r <= 1'b1;
      drvLow_r <= 1'b0;
    end
    else
    begin
      if (startSeen)
      begin
        code_r <= 3'h0;
        remain_r <= frameLen(3'h0, syncFmt);
        firstFrame_r <= 1'b1;
        active_r <= ~master;
      end
      else if (frameEnd)
      begin
        code_r <= 3'h0;
        remain_r <= frameLen(3'h0, syncFmt);
        firstFrame_r <= 1'b0;
        rxData_r <= ~transmit ? rxByte : rxData_r;
        // A master keeps going while data waits and no halt is due.
        active_r <= ~master | (txFull_r & ~judgeHalt);
      end
      else if (judgeHalt | arbHit | stopSeen)
        active_r <= 1'b0;
      else if (wrCount & ~active_r)
      begin
        code_r <= hwdata[2:0];
        remain_r <= frameLen(hwdata[2:0], syncFmt);
      end
      else if (launch | (~master & syncFmt & ~active_r & sclFall))
        active_r <= 1'b1;
      if (sample & ~lastBit)
      begin
        remain_r <= remain_r - 4'h1;
        // A transmitter shifts only at a fall or a master launch, never twice per bit.
        if (~transmit)
          shift_r <= shiftIn;
      end
      // Place the next bit on the data line while SCL is low.
      if (present | launch)
      begin
        if (ackBit)
        begin
          bitVal_r <= transmit ? 1'b1 : ier_r.ackToSend;
          drvLow_r <= ~transmit & ~ier_r.ackToSend;
        end
        else if (transmit)
        begin
          shift_r <= fullLen ? shiftMove & 8'hFF : shiftMove;
          if (fullLen)
          begin
            shift_r <= lsbFirst_r ? {1'b0, txData_r[7:1]}
                                  : {txData_r[6:0], 1'b0};
          end
          bitVal_r <= fullLen ? (lsbFirst_r ? txData_r[0] : txData_r[7])
                              : outBit;
          drvLow_r <= fullLen ? ~(lsbFirst_r ? txData_r[0] : txData_r[7])
                              : ~outBit;
        end
        else
        begin
          bitVal_r <= 1'b1;
          drvLow_r <= 1'b0;
        end
      end
      else if (~active_r)
      begin
        bitVal_r <= 1'b1;
        drvLow_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Master SCL generator with optional wait before the ack bit.
  // ==========================================================
  // Stretching of SCL by a slave is not observed in this generator.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      gen_r <= GEN_IDLE;
      sclGen_r <= 1'b1;
      tickCnt_r <= 16'h0000;
      phaseCnt_r <= 4'h0;
    end
    else
    begin
      // Held at zero while idle so the first low phase is full length.
      tickCnt_r <= (tick || gen_r == GEN_IDLE) ? 16'h0000
                                               : tickCnt_r + 16'h0001;
      case (gen_r)
        GEN_IDLE:
        begin
          sclGen_r <= 1'b1;
          phaseCnt_r <= 4'h0;
          if (launch)
          begin
            gen_r <= GEN_LOW;
            sclGen_r <= 1'b0;
          end
        end
        GEN_LOW, GEN_WAIT:
        begin
          if (tick)
            phaseCnt_r <= phaseCnt_r + 4'h1;
          // Wait phase lasts two transfer clocks, then a normal low.
          if (tick && gen_r == GEN_WAIT &&
              phaseCnt_r == i2c_ack_irq_pkg::WAIT_TICKS - 4'h1)
          begin
            gen_r <= GEN_LOW;
            phaseCnt_r <= 4'h0;
          end
          else if (tick && gen_r == GEN_LOW &&
                   phaseCnt_r == 4'(HALF_TICKS - 1))
          begin
            gen_r <= GEN_HIGH;
            sclGen_r <= 1'b1;
            phaseCnt_r <= 4'h0;
          end
        end
        GEN_HIGH:
        begin
          if (tick)
            phaseCnt_r <= phaseCnt_r + 4'h1;
          if (tick && phaseCnt_r == 4'(HALF_TICKS - 1))
          begin
            phaseCnt_r <= 4'h0;
            if (!active_r || !master)
              gen_r <= GEN_IDLE;
            else
            begin
              sclGen_r <= 1'b0;
              // After the final data bit, stretch low before the ack.
              gen_r <= (waitUse && ackBit) ? GEN_WAIT : GEN_LOW;
            end
          end
        end
        default:
          gen_r <= GEN_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pin drivers: open drain in two-wire, push-pull in synchronous.
  // ==========================================================
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclOut <= 1'b0;
      sclOe <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
    end
    else
    begin
      sclOut <= syncFmt & sclGen_r;
      sclOe <= master & (syncFmt | ~sclGen_r);
      sdaOut <= syncFmt & bitVal_r;
      sdaOe <= syncFmt ? (transmit & active_r) : drvLow_r;
    end
  end

  // Bus answer is fixed: no wait states, no error response.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule : i2c_ack_and_interrupt_control

// *** i2c_ack_irq_chk.sv ***
/*
  Checker: interrupt request gating at the top module's ports.
  Assumes it is bound by name to i2c_ack_and_interrupt_control.
*/
`timescale 1ns/100ps
module i2c_ack_irq_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire i2c_ack_irq_pkg::irq_type irqLines,
  input wire logic irq
);
  // ==========================================================
  // Mirror of the enable register.
  // ==========================================================
  i2c_ack_irq_pkg::ier_type ier_r; // Enables as software wrote them.
  logic wrPend_r; // A write to the enable register is in data phase.
  wire wrHit = hsel && htrans[1] && hready && hwrite;
  // The mirror updates at the data-phase edge, as the register does.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPend_r <= 1'b0;
      ier_r <= '0;
    end
    else
    begin
      wrPend_r <= wrHit && (haddr == 32'h000002EC);
      if (wrPend_r)
        ier_r <= hwdata[7:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_stop_gate: assert property (irqLines.stopSeen |-> $past(ier_r.stopIrqEnable))
    else $error("stop request without enable");
  a_noack_gate: assert property (irqLines.noackErr |-> $past(ier_r.noackIrqEnable))
    else $error("noack request without enable");
  a_rx_gate: assert property (irqLines.rxFull |-> $past(ier_r.rxIrqEnable))
    else $error("receive request without enable");
  a_txend_gate: assert property (irqLines.txEnd |-> $past(ier_r.txEndIrqEnable))
    else $error("transmit end request without enable");
  a_txempty_gate: assert property (irqLines.txEmpty |-> $past(ier_r.txEmptyIrqEnable))
    else $error("transmit empty request without enable");
  a_irq_or: assert property (irq == (|irqLines))
    else $error("irq differs from its request lines");
  a_reset_clear: assert property ($rose(nrst) |-> irqLines == '0 && !irq)
    else $error("request active after reset");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
endmodule : i2c_ack_irq_chk

// *** i2c_far_slave.sv ***
/*
  Behavioural far-side device on the two-wire link.
  Assumes SCL and SDA are open-drain lines with pull-ups.
*/
`timescale 1ns/100ps
module i2c_far_slave (
  input wire logic scl,
  input wire logic sda,
  input wire logic sendData,
  input wire logic [7:0] txByte,
  input wire logic ackVal,
  output logic sdaPull,
  output logic seenAck,
  output logic [7:0] gotByte
);
  int bitNum; // Bit of the nine-bit frame in progress.
  initial
  begin
    bitNum = 0;
    sdaPull = 1'b0;
    seenAck = 1'b1;
    gotByte = 8'h00;
  end
  // Each SCL fall starts the next bit; data goes out MSB first.
  always @(negedge scl)
  begin
    bitNum = (bitNum % 9) + 1;
    if (bitNum <= 8)
      sdaPull = sendData && !txByte[8 - bitNum];
    else
      sdaPull = !sendData && !ackVal;
  end
  // Data rises collect the byte; the ninth rise carries the acknowledge.
  // The line is let go only at the next fall, never while SCL is high.
  always @(posedge scl)
  begin
    if (bitNum <= 8)
      gotByte = {gotByte[6:0], sda};
    if (bitNum == 9)
      seenAck = sda;
  end
endmodule : i2c_far_slave

// *** i2c_ack_and_interrupt_control_test.sv ***
/*
  Testbench: register and frame sequences over AHB-Lite.
  Assumes pull-ups on both link lines and the far-side model.
*/
`timescale 1ns/100ps
module i2c_ack_and_interrupt_control_test;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, sclOut, sclOe, sdaOut, sdaOe, irq;
  logic [31:0] hrdata, rd;
  i2c_ack_irq_pkg::irq_type irqLines;
  logic sendData = 1'b0;
  logic ackVal = 1'b0;
  logic startPull = 1'b0; // Makes a start condition from outside.
  logic sdaPull, seenAck;
  logic [7:0] gotByte; // Byte the far side collected.
  int maxLow = 0; // Longest SCL low run of the last frame, in mclk.
  wire scl = !(sclOe && !sclOut);
  wire sda = !((sdaOe && !sdaOut) || sdaPull || startPull);
  int bad_count = 0;
  int samples_checked = 0;
  always #10 mclk = !mclk;
  i2c_ack_and_interrupt_control #(.XFER_DIV(4), .HALF_TICKS(1)) dut_u (
    .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .irqLines(irqLines),
    .irq(irq));
  i2c_far_slave far_u (.scl(scl), .sda(sda), .sendData(sendData),
    .txByte(8'h00), .ackVal(ackVal), .sdaPull(sdaPull), .seenAck(seenAck),
    .gotByte(gotByte));
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check
  // Waits for hready; a wait that runs out ends the run.
  task automatic waitReady;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask : waitReady
  task automatic bus(input logic wr, input logic [7:0] idx,
    input logic [7:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    waitReady();
    rd = hrdata;
  endtask : bus
  task automatic chkRd(input logic [7:0] idx, input logic [7:0] want);
    bus(1'b0, idx, 8'h00);
    check(rd, {24'h0, want});
  endtask : chkRd
  // Waits until SCL has stayed high long enough to call the frame over.
  task automatic frameWait;
    int n;
    int hi;
    int lo;
    n = 0;
    hi = 0;
    lo = 0;
    maxLow = 0;
    while (hi < 30 && n < 3000)
    begin
      @(posedge mclk);
      n++;
      hi = scl ? hi + 1 : 0;
      lo = scl ? 0 : lo + 1;
      maxLow = (lo > maxLow) ? lo : maxLow;
    end
    if (n >= 3000)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask : frameWait
  initial
  begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    chkRd(8'hBB, 8'h00);
    bus(1'b1, 8'hBA, 8'h0B); // Guard bit one: counter must hold.
    chkRd(8'hBA, 8'h18);
    bus(1'b1, 8'hBA, 8'h03); // Written in two-wire format.
    chkRd(8'hBA, 8'h1B);
    bus(1'b1, 8'hBA, 8'h00);
    chkRd(8'hC0, 8'h00);
    bus(1'b1, 8'hBD, 8'h03); // Master transmitter, two-wire.
    bus(1'b1, 8'hBB, 8'h5C); // Judge on; end, noack and stop requests enabled.
    for (int a = 0; a < 2; a++)
    begin
      ackVal <= a[0];
      bus(1'b1, 8'hBE, 8'hA5);
      frameWait();
      chkRd(8'hBA, 8'h18);
      chkRd(8'hBB, {6'h17, a[0], 1'b0});
      check({31'h0, irqLines.noackErr}, {31'h0, a[0]});
      check({24'h0, gotByte}, 32'hA5);
      check(maxLow, 4);
    end
    // Wait on: one transfer clock low plus two waited, four mclk each.
    bus(1'b1, 8'hBA, 8'h48); // Guard bit one: counter kept.
    bus(1'b1, 8'hBE, 8'hA5);
    frameWait();
    check(maxLow, 12);
    bus(1'b1, 8'hBB, 8'h4C);
    bus(1'b0, 8'hBC, 8'h00);
    check({31'h0, irqLines.noackErr}, 32'h0);
    check({31'h0, rd[4]}, 32'h1);
    bus(1'b1, 8'hBC, 8'h10);
    bus(1'b1, 8'hBD, 8'h01); // Master receiver, two-wire.
    sendData <= 1'b1;
    for (int a = 1; a >= 0; a--)
    begin
      bus(1'b1, 8'hBB, {7'h10, a[0]});
      startPull <= 1'b1;
      bus(1'b1, 8'hBE, 8'h00);
      repeat (20) @(posedge mclk);
      startPull <= 1'b0;
      frameWait();
      check({31'h0, seenAck}, {31'h0, a[0]});
      check({31'h0, irqLines.rxFull}, 32'h1);
      chkRd(8'hBE, 8'h00);
    end
    bus(1'b0, 8'hBC, 8'h00);
    check({31'h0, rd[0]}, 32'h1);
    check({31'h0, rd[2]}, 32'h0);
    report_and_stop();
  end
endmodule : i2c_ack_and_interrupt_control_test
bind i2c_ack_and_interrupt_control i2c_ack_irq_chk chk_u (.mclk(mclk),
  .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hreadyout(hreadyout), .hresp(hresp), .irqLines(irqLines), .irq(irq));
